// *** logic/pec_ext_ctl.sv ***
`timescale 1ns/1ps
// What this block does
// - Squelch field 10 raises squelch threshold
// - Sticky enable set keeps sticky bits
// - Sticky enable clear restores sticky defaults
// - Super-sticky bits always survive software reset
// - Broadcast bit applies writes to every PHY
// - Reads answer only the addressed PHY
// - Broadcast clear restores addressed-only writes
// - Receive clock follows recovered or reference
// - Clock source ignored in RMII mode
// - Interface select MII, RMII, RGMII; default RGMII
// - Mode bits apply at software reset
// - Mode reads show mode in force
// - Edge rate field, sticky, default 000
// - Sticky reduced-power mode enable
// - Sticky jumbo length field, default 1.5 kB
// - Default jumbo limits assume 100 ppm
// - Sticky enable is super-sticky, default one
// - Squelch codes normal, low, high, reserved
module pec_ext_ctl (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [4:0]  phy_addr_i,
    input  wire logic        mgmt_wr_i,
    input  wire logic        mgmt_rd_i,
    input  wire logic [4:0]  mgmt_phy_i,
    input  wire logic [4:0]  mgmt_reg_i,
    input  wire logic [15:0] mgmt_wdata_i,
    input  wire logic        low_power_hold_state_i,
    input  wire logic [7:0]  ref_clk_ppm_i,
    output logic      [15:0] mgmt_rdata_o,
    output logic             mgmt_rvalid_o,
    output logic             soft_reset_o,
    output logic      [1:0]  squelch_level_o,
    output logic             squelch_raised_o,
    output logic             broadcast_wr_o,
    output logic      [1:0]  mac_if_sel_o,
    output logic             rx_clk_from_ref_o,
    output logic             far_loopback_o,
    output logic      [2:0]  edge_rate_o,
    output logic             reduced_power_o,
    output logic      [14:0] max_pkt_len_o,
    output logic             connector_loopback_o
);
    // ======================================================================
    // Reset release
    logic [1:0] rst_q;
    logic       rst_n;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ======================================================================
    // Length decode
    function automatic logic [14:0] pkt_len(input logic [1:0] mode, input logic [7:0] ppm);
        logic [14:0] len;
        len = pec_pkg::LEN_STD;
        case (mode)
            pec_pkg::JUMBO_9K: begin
                len = (ppm <= pec_pkg::PPM_FOR_12K) ? pec_pkg::LEN_12K : pec_pkg::LEN_9K;
            end
            pec_pkg::JUMBO_12K: begin
                len = (ppm <= pec_pkg::PPM_FOR_16K) ? pec_pkg::LEN_16K : pec_pkg::LEN_12K;
            end
            default: begin
                len = pec_pkg::LEN_STD;
            end
        endcase
        return len;
    endfunction

    // ======================================================================
    // Write acceptance and software reset
    logic [15:0] ext_status;
    logic [15:0] ctl_two;
    logic        far_loop;
    logic        sticky_en;
    logic        bcast;
    logic        addr_hit;
    logic        wr_ok;
    logic        soft_rst;
    logic [15:0] next_ext_status;
    logic [15:0] next_ctl_two;

    assign sticky_en = ext_status[pec_pkg::STICKY_EN_BIT];
    assign bcast     = ext_status[pec_pkg::BCAST_BIT];
    assign addr_hit  = (mgmt_phy_i == phy_addr_i);
    assign wr_ok     = mgmt_wr_i && (addr_hit || bcast);
    assign soft_rst  = wr_ok && (mgmt_reg_i == pec_pkg::REG_CONTROL)
                       && mgmt_wdata_i[pec_pkg::SOFT_RESET_BIT];

    always_comb begin
        if (sticky_en) begin
            next_ext_status = ext_status;
            next_ctl_two    = ctl_two & pec_pkg::CTL_TWO_STICKY;
        end else begin
            next_ext_status = (pec_pkg::EXT_STATUS_DEF & ~pec_pkg::SUPER_STICKY)
                              | (ext_status & pec_pkg::SUPER_STICKY);
            next_ctl_two    = pec_pkg::CTL_TWO_DEF;
        end
    end

    // ======================================================================
    // Extended control and status register
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_status <= pec_pkg::EXT_STATUS_DEF;
        end else if (soft_rst) begin
            ext_status <= next_ext_status;
        end else if (wr_ok && mgmt_reg_i == pec_pkg::REG_EXT_STATUS) begin
            ext_status <= mgmt_wdata_i & pec_pkg::EXT_STATUS_MASK;
        end
    end

    // ======================================================================
    // Extended control two register
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctl_two <= pec_pkg::CTL_TWO_DEF;
        end else if (soft_rst) begin
            ctl_two <= next_ctl_two;
        end else if (wr_ok && mgmt_reg_i == pec_pkg::REG_EXT_CTL_TWO) begin
            ctl_two <= mgmt_wdata_i & pec_pkg::CTL_TWO_MASK;
        end
    end

    // ======================================================================
    // Extended control one: loopback and interface mode
    pec_mode_if mif ();

    assign mif.wr       = wr_ok && (mgmt_reg_i == pec_pkg::REG_EXT_CTL_ONE);
    assign mif.wdata    = mgmt_wdata_i[pec_pkg::RXCLK_SRC_BIT:pec_pkg::MAC_IF_LSB];
    assign mif.soft_rst = soft_rst;
    assign mif.hold     = low_power_hold_state_i;

    pec_mac_mode u_mode (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n),
        .m       (mif.mode)
    );

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            far_loop <= 1'b0;
        end else if (soft_rst) begin
            far_loop <= 1'b0;
        end else if (mif.wr) begin
            far_loop <= mgmt_wdata_i[pec_pkg::FAR_LOOP_BIT];
        end
    end

    // ======================================================================
    // Read path
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata_o  <= 16'h0000;
            mgmt_rvalid_o <= 1'b0;
        end else begin
            mgmt_rvalid_o <= mgmt_rd_i && addr_hit;
            if (mgmt_rd_i && addr_hit) begin
                case (mgmt_reg_i)
                    pec_pkg::REG_EXT_STATUS: begin
                        mgmt_rdata_o <= ext_status;
                    end
                    pec_pkg::REG_EXT_CTL_ONE: begin
                        mgmt_rdata_o <= {2'h0, mif.active, 7'h00, far_loop, 3'h0};
                    end
                    pec_pkg::REG_EXT_CTL_TWO: begin
                        mgmt_rdata_o <= ctl_two;
                    end
                    default: begin
                        mgmt_rdata_o <= 16'h0000;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // Control outputs
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_o         <= 1'b0;
            squelch_level_o      <= 2'h0;
            squelch_raised_o     <= 1'b0;
            broadcast_wr_o       <= 1'b0;
            mac_if_sel_o         <= pec_pkg::MODE_DEF[1:0];
            rx_clk_from_ref_o    <= 1'b0;
            far_loopback_o       <= 1'b0;
            edge_rate_o          <= 3'h0;
            reduced_power_o      <= 1'b0;
            max_pkt_len_o        <= pec_pkg::LEN_STD;
            connector_loopback_o <= 1'b0;
        end else begin
            soft_reset_o         <= soft_rst;
            squelch_level_o      <= ext_status[pec_pkg::SQUELCH_LSB +: 2];
            squelch_raised_o     <= ext_status[pec_pkg::SQUELCH_LSB +: 2]
                                    == pec_pkg::SQUELCH_HIGH;
            broadcast_wr_o       <= bcast;
            mac_if_sel_o         <= mif.active[1:0];
            rx_clk_from_ref_o    <= mif.active[2]
                                    && (mif.active[1:0] != pec_pkg::MAC_IF_RMII);
            far_loopback_o       <= far_loop;
            edge_rate_o          <= ctl_two[pec_pkg::EDGE_LSB +: 3];
            reduced_power_o      <= ctl_two[pec_pkg::LOW_PWR_BIT];
            max_pkt_len_o        <= pkt_len(ctl_two[pec_pkg::JUMBO_LSB +: 2],
                                            ref_clk_ppm_i);
            connector_loopback_o <= ctl_two[0];
        end
    end

    // ======================================================================
    // Assertions
    AST_SQUELCH_HIGH: assert property (@(posedge mclk_i) disable iff (!rst_n)
        1'b1 |=> (squelch_raised_o
                  == ($past(ext_status[pec_pkg::SQUELCH_LSB +: 2]) == pec_pkg::SQUELCH_HIGH)))
        else $error("Raised squelch does not match squelch code");

    AST_STICKY_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (soft_rst && sticky_en) |=> (ctl_two[15:4] == $past(ctl_two[15:4]))
        && (ext_status == $past(ext_status)))
        else $error("Sticky bits lost on soft reset with retention on");

    AST_STICKY_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (soft_rst && !sticky_en) |=> (ctl_two == pec_pkg::CTL_TWO_DEF)
        && (ext_status[15:10] == pec_pkg::EXT_STATUS_DEF[15:10]) && !ext_status[0])
        else $error("Sticky bits not restored on soft reset");

    AST_SUPER_STICKY: assert property (@(posedge mclk_i) disable iff (!rst_n)
        soft_rst |=> $stable(sticky_en))
        else $error("Super-sticky bit changed on soft reset");

    AST_BCAST_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mgmt_wr_i && bcast && !addr_hit && mgmt_reg_i == pec_pkg::REG_EXT_CTL_TWO)
        |=> ##1 (edge_rate_o == $past(mgmt_wdata_i[15:13], 2)))
        else $error("Broadcast write not applied");

    AST_READ_ADDRESSED: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mgmt_rd_i && !addr_hit) |=> !mgmt_rvalid_o)
        else $error("Read answered for another PHY");

    AST_NO_FOREIGN_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mgmt_wr_i && !bcast && !addr_hit) |=> $stable(ctl_two) && $stable(ext_status))
        else $error("Write to another PHY changed registers");

    AST_RMII_CLK: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mac_if_sel_o == pec_pkg::MAC_IF_RMII) |-> !rx_clk_from_ref_o)
        else $error("Clock source applied in RMII mode");

    AST_MODE_DEFERRED: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mif.wr && !soft_rst && !low_power_hold_state_i) |=> $stable(mif.active))
        else $error("Mode changed without soft reset");

    AST_JUMBO_LEN: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ctl_two[5:4] == pec_pkg::JUMBO_NORMAL) |=> (max_pkt_len_o == pec_pkg::LEN_STD))
        else $error("Normal packet length wrong");

    AST_HOLD_APPLY: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mif.wr && low_power_hold_state_i) |=> (mif.active == $past(mif.wdata)))
        else $error("Mode written in hold state not applied");

    AST_SOFT_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n)
        soft_rst |=> soft_reset_o)
        else $error("Soft reset pulse missing");

    AST_RXCLK_SRC: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mif.active[1:0] != pec_pkg::MAC_IF_RMII)
        |=> (rx_clk_from_ref_o == $past(mif.active[2])))
        else $error("Receive clock source does not follow mode");

    AST_MODE_READ: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mgmt_rd_i && addr_hit && mgmt_reg_i == pec_pkg::REG_EXT_CTL_ONE)
        |=> (mgmt_rdata_o[13:11] == $past(mif.active)))
        else $error("Mode read does not show mode in force");

    AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (mgmt_rd_i && addr_hit && mgmt_reg_i == pec_pkg::REG_EXT_STATUS)
        |=> (mgmt_rdata_o[8:1] == 8'h00))
        else $error("Reserved status bits read nonzero");

    AST_REDUCED_PWR: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (wr_ok && mgmt_reg_i == pec_pkg::REG_EXT_CTL_TWO)
        |=> ##1 (reduced_power_o == $past(mgmt_wdata_i[pec_pkg::LOW_PWR_BIT], 2)))
        else $error("Reduced power enable not applied");

    AST_JUMBO_LONG: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ctl_two[5:4] == pec_pkg::JUMBO_12K && ref_clk_ppm_i <= pec_pkg::PPM_FOR_16K)
        |=> (max_pkt_len_o == pec_pkg::LEN_16K))
        else $error("Tight clock jumbo length wrong");

    AST_LOOP_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_n)
        soft_rst |=> ##1 (!connector_loopback_o && !far_loopback_o))
        else $error("Loopback kept over soft reset");

    COV_BCAST: cover property (@(posedge mclk_i) disable iff (!rst_n)
        mgmt_wr_i && bcast && !addr_hit);
    COV_SOFT_KEEP: cover property (@(posedge mclk_i) disable iff (!rst_n)
        soft_rst && sticky_en);
    COV_MODE_APPLY: cover property (@(posedge mclk_i) disable iff (!rst_n)
        soft_rst ##1 !$stable(mif.active));
    COV_HOLD_WRITE: cover property (@(posedge mclk_i) disable iff (!rst_n)
        mif.wr && low_power_hold_state_i);
endmodule // pec_ext_ctl

// *** logic/pec_mac_mode.sv ***
`timescale 1ns/1ps
module pec_mac_mode (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    pec_mode_if.mode  m
);
    // ======================================================================
    // Pending and operating interface mode
    logic [2:0] pending;
    logic [2:0] active;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending <= pec_pkg::MODE_DEF;
        end else if (m.wr) begin
            pending <= m.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active <= pec_pkg::MODE_DEF;
        end else if (m.hold && m.wr) begin
            active <= m.wdata;
        end else if (m.soft_rst || m.hold) begin
            active <= pending;
        end
    end

    assign m.active = active;
endmodule // pec_mac_mode

// *** logic/pec_mode_if.sv ***
`timescale 1ns/1ps
interface pec_mode_if;
    logic       wr;
    logic [2:0] wdata;
    logic       soft_rst;
    logic       hold;
    logic [2:0] active;
    modport ctl  (output wr, output wdata, output soft_rst, output hold, input active);
    modport mode (input wr, input wdata, input soft_rst, input hold, output active);
endinterface

// *** logic/pec_pkg.sv ***
package pec_pkg;
    // ======================================================================
    // Register addresses
    localparam logic [4:0]  REG_CONTROL     = 5'h00;
    localparam logic [4:0]  REG_EXT_STATUS  = 5'h16;
    localparam logic [4:0]  REG_EXT_CTL_ONE = 5'h17;
    localparam logic [4:0]  REG_EXT_CTL_TWO = 5'h18;
    // ======================================================================
    // Field positions
    localparam int          SOFT_RESET_BIT  = 15;
    localparam int          STICKY_EN_BIT   = 9;
    localparam int          BCAST_BIT       = 0;
    localparam int          SQUELCH_LSB     = 10;
    localparam int          RXCLK_SRC_BIT   = 13;
    localparam int          MAC_IF_LSB      = 11;
    localparam int          FAR_LOOP_BIT    = 3;
    localparam int          EDGE_LSB        = 13;
    localparam int          LOW_PWR_BIT     = 12;
    localparam int          JUMBO_LSB       = 4;
    // ======================================================================
    // Masks and values after reset
    localparam logic [15:0] EXT_STATUS_MASK = 16'hfe01;
    localparam logic [15:0] SUPER_STICKY    = 16'h0200;
    localparam logic [15:0] EXT_STATUS_DEF  = 16'h3200;
    localparam logic [15:0] CTL_TWO_MASK    = 16'hf031;
    localparam logic [15:0] CTL_TWO_STICKY  = 16'hf030;
    localparam logic [15:0] CTL_TWO_DEF     = 16'h0000;
    localparam logic [2:0]  MODE_DEF        = 3'h2;
    // ======================================================================
    // Encodings
    localparam logic [1:0]  SQUELCH_HIGH    = 2'h2;
    localparam logic [1:0]  MAC_IF_RMII     = 2'h1;
    localparam logic [1:0]  JUMBO_NORMAL    = 2'h0;
    localparam logic [1:0]  JUMBO_9K        = 2'h1;
    localparam logic [1:0]  JUMBO_12K       = 2'h2;
    // ======================================================================
    // Packet lengths in bytes and clock tolerances in ppm
    localparam logic [14:0] LEN_STD         = 15'h0600;
    localparam logic [14:0] LEN_9K          = 15'h2400;
    localparam logic [14:0] LEN_12K         = 15'h3000;
    localparam logic [14:0] LEN_16K         = 15'h4000;
    localparam logic [7:0]  PPM_FOR_12K     = 8'h3c;
    localparam logic [7:0]  PPM_FOR_16K     = 8'h46;
endpackage

// *** testbench/pec_mgmt_model.sv ***
`timescale 1ns/1ps
// ======================================================================
// Station manager driving the parallel request port
module pec_mgmt_model (
    input  wire logic        clk_i,
    input  wire logic        rvalid_i,
    input  wire logic [15:0] rdata_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [4:0]  phy_o,
    output logic      [4:0]  reg_o,
    output logic      [15:0] wdata_o
);
    initial begin
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        phy_o   = 5'h00;
        reg_o   = 5'h00;
        wdata_o = 16'h0000;
    end

    task automatic write(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
        @(negedge clk_i);
        phy_o   = phy;
        reg_o   = rg;
        wdata_o = d;
        wr_o    = 1'b1;
        @(negedge clk_i);
        wr_o    = 1'b0;
        wdata_o = ~d;
    endtask

    // Mode bits apply once the manager issues this reset, or at once in the low-power hold state
    task automatic soft_reset(input logic [4:0] phy);
        write(phy, 5'h00, 16'h8000);
    endtask

    task automatic read(input logic [4:0] phy, input logic [4:0] rg, output logic got,
                        output logic [15:0] d);
        got = 1'b0;
        d   = 16'h0000;
        @(negedge clk_i);
        phy_o = phy;
        reg_o = rg;
        rd_o  = 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk_i);
            rd_o = 1'b0;
            if (rvalid_i === 1'b1) begin
                got = 1'b1;
                d   = rdata_i;
            end
        end
    endtask
endmodule // pec_mgmt_model

// *** testbench/phy_ext_control_regs_tb.sv ***
`timescale 1ns/1ps
module phy_ext_control_regs_tb;
    localparam logic [4:0] ME = 5'h05;
    localparam logic [4:0] OT = 5'h0a;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, wr, rd, hold = 1'b0, rvalid, srst, raised, bcast;
    logic rxref, farlb, redpwr, connlb;
    logic [4:0]  phy, rg;
    logic [15:0] wd, rdata;
    logic [7:0]  ppm = 8'h64;
    logic [1:0]  sq, mac;
    logic [2:0]  edge_r;
    logic [14:0] pkt;
    int          n_fail = 0, samples_checked = 0;

    always #20 mclk_i = ~mclk_i;

    pec_mgmt_model u_mgr (.clk_i(mclk_i), .rvalid_i(rvalid), .rdata_i(rdata), .wr_o(wr),
        .rd_o(rd), .phy_o(phy), .reg_o(rg), .wdata_o(wd));

    pec_ext_ctl dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .phy_addr_i(ME), .mgmt_wr_i(wr),
        .mgmt_rd_i(rd), .mgmt_phy_i(phy), .mgmt_reg_i(rg), .mgmt_wdata_i(wd),
        .low_power_hold_state_i(hold), .ref_clk_ppm_i(ppm), .mgmt_rdata_o(rdata),
        .mgmt_rvalid_o(rvalid), .soft_reset_o(srst), .squelch_level_o(sq),
        .squelch_raised_o(raised), .broadcast_wr_o(bcast), .mac_if_sel_o(mac),
        .rx_clk_from_ref_o(rxref), .far_loopback_o(farlb), .edge_rate_o(edge_r),
        .reduced_power_o(redpwr), .max_pkt_len_o(pkt), .connector_loopback_o(connlb));

    // ======================================================================
    // Shared helpers
    task automatic end_sim();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [4:0] p, input logic [4:0] r, input logic [15:0] exp);
        logic        got;
        logic [15:0] d;
        u_mgr.read(p, r, got, d);
        chk(16'(got), 16'h0001);
        chk(d, exp);
    endtask

    task automatic wr_me(input logic [4:0] r, input logic [15:0] d);
        u_mgr.write(ME, r, d);
        repeat (2) @(negedge mclk_i);
    endtask

    task automatic sreset();
        u_mgr.soft_reset(ME);
        chk(16'(srst), 16'h0001);
        repeat (3) @(negedge mclk_i);
        chk(16'(srst), 16'h0000);
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_defaults();
        rchk(ME, pec_pkg::REG_EXT_STATUS, pec_pkg::EXT_STATUS_DEF);
        rchk(ME, pec_pkg::REG_EXT_CTL_ONE, 16'h1000);
        rchk(ME, pec_pkg::REG_EXT_CTL_TWO, 16'h0000);
        rchk(ME, 5'h1f, 16'h0000);
        chk(16'(mac), 16'h0002);
        chk(16'(pkt), 16'h0600);
    endtask

    task automatic t_squelch();
        for (int c = 0; c < 3; c++) begin
            wr_me(pec_pkg::REG_EXT_STATUS, 16'h32fe | 16'(c << 10));
            chk(16'(sq), 16'(c));
            chk(16'(raised), 16'(c == 2));
            rchk(ME, pec_pkg::REG_EXT_STATUS, 16'h3200 | 16'(c << 10));
        end
    endtask

    task automatic t_sticky();
        wr_me(pec_pkg::REG_EXT_CTL_TWO, 16'h7fff);
        chk({13'h0, edge_r}, 16'h0003);
        chk({14'h0, redpwr, connlb}, 16'h0003);
        rchk(ME, pec_pkg::REG_EXT_CTL_TWO, 16'h7031);
        sreset();
        rchk(ME, pec_pkg::REG_EXT_CTL_TWO, 16'h7030);
        rchk(ME, pec_pkg::REG_EXT_STATUS, 16'h3a00);
        wr_me(pec_pkg::REG_EXT_STATUS, 16'h0800);
        sreset();
        rchk(ME, pec_pkg::REG_EXT_STATUS, 16'h3000);
        rchk(ME, pec_pkg::REG_EXT_CTL_TWO, 16'h0000);
        chk({13'h0, edge_r}, 16'h0000);
        wr_me(pec_pkg::REG_EXT_STATUS, 16'h3200);
    endtask

    task automatic t_mode();
        wr_me(pec_pkg::REG_EXT_CTL_ONE, 16'h2808);
        chk({14'h0, mac}, 16'h0002);
        chk(16'(farlb), 16'h0001);
        rchk(ME, pec_pkg::REG_EXT_CTL_ONE, 16'h1008);
        sreset();
        chk({14'h0, mac}, 16'h0001);
        chk(16'(rxref), 16'h0000);
        rchk(ME, pec_pkg::REG_EXT_CTL_ONE, 16'h2800);
        wr_me(pec_pkg::REG_EXT_CTL_ONE, 16'h2000);
        sreset();
        chk({13'h0, rxref, mac}, 16'h0004);
        hold = 1'b1;
        wr_me(pec_pkg::REG_EXT_CTL_ONE, 16'h1000);
        @(negedge mclk_i);
        chk({13'h0, rxref, mac}, 16'h0002);
        hold = 1'b0;
    endtask

    task automatic t_bcast();
        logic        got;
        logic [15:0] d;
        u_mgr.write(OT, pec_pkg::REG_EXT_CTL_TWO, 16'h2000);
        rchk(ME, pec_pkg::REG_EXT_CTL_TWO, 16'h0000);
        wr_me(pec_pkg::REG_EXT_STATUS, 16'h3201);
        chk(16'(bcast), 16'h0001);
        u_mgr.write(OT, pec_pkg::REG_EXT_CTL_TWO, 16'h2000);
        repeat (2) @(negedge mclk_i);
        chk({13'h0, edge_r}, 16'h0001);
        u_mgr.read(OT, pec_pkg::REG_EXT_CTL_TWO, got, d);
        chk(16'(got), 16'h0000);
        rchk(ME, pec_pkg::REG_EXT_CTL_TWO, 16'h2000);
        u_mgr.write(OT, pec_pkg::REG_EXT_STATUS, 16'h3200);
        u_mgr.write(OT, pec_pkg::REG_EXT_CTL_TWO, 16'h4000);
        repeat (2) @(negedge mclk_i);
        chk({12'h0, bcast, edge_r}, 16'h0001);
    endtask

    task automatic jcase(input logic [1:0] c, input logic [7:0] p, input logic [14:0] len);
        ppm = p;
        wr_me(pec_pkg::REG_EXT_CTL_TWO, {10'h000, c, 4'h0});
        chk(16'(pkt), 16'(len));
    endtask

    task automatic t_jumbo();
        jcase(2'h0, 8'h64, 15'h0600);
        jcase(2'h1, 8'h64, 15'h2400);
        jcase(2'h1, 8'h3c, 15'h3000);
        jcase(2'h2, 8'h64, 15'h3000);
        jcase(2'h2, 8'h46, 15'h4000);
        jcase(2'h3, 8'h64, 15'h0600);
    endtask

    task automatic t_hw_reset();
        u_mgr.write(ME, pec_pkg::REG_CONTROL, 16'h7fff);
        chk(16'(srst), 16'h0000);
        u_mgr.soft_reset(OT);
        chk(16'(srst), 16'h0000);
        wr_me(pec_pkg::REG_EXT_STATUS, 16'h0000);
        reset_n_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        t_defaults();
    endtask

    // ======================================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        t_defaults();
        t_squelch();
        t_sticky();
        t_mode();
        t_bcast();
        t_jumbo();
        t_hw_reset();
        end_sim();
    end

    initial begin
        #2000000;
        n_fail++;
        end_sim();
    end
endmodule // phy_ext_control_regs_tb
